/* File: uhis_defs.vh */
// constants for the interrupt status block
`ifndef UHIS_DEFS_VH
`define UHIS_DEFS_VH
`define UHIS_ADDR_STATUS 8'h0D
`define UHIS_ADDR_REV 8'h0E
`define UHIS_BIT_DPLUS 7
`define UHIS_BIT_DETECT 6
`define UHIS_BIT_INSRM 5
`define UHIS_BIT_SOF 4
`define UHIS_BIT_DONE_B 1
`define UHIS_BIT_DONE_A 0
`define UHIS_STICKY_MASK 8'h73
`define UHIS_PIN_MASK 8'h7F
`define UHIS_REV_RSVD 4'h0
`define UHIS_REV_SHIFT 4
`define UHIS_ZERO8 8'h00
`define UHIS_LINE_SE0 2'b00
`define UHIS_LINE_IDLE_FS 2'b10
`define UHIS_LINE_IDLE_LS 2'b01
`endif

/* File: uhis_line_watch.v */
// bus line state watcher: flags se0/idle transitions
`timescale 1ns/1ps
`default_nettype none
`include "uhis_defs.vh"
module uhis_line_watch (
    // clock and reset
    input wire mclk_i,
    input wire rst_n_i,
    input wire ce_i,
    // line levels
    input wire dplus_i,
    input wire dminus_i,
    // result
    output wire change_o
);
    reg [1:0] prev_reg;
    reg seen_reg;
    wire [1:0] line;
    wire is_se0;
    wire was_se0;
    wire is_idle;
    wire was_idle;
    assign line = {dplus_i, dminus_i};
    assign is_se0 = (line == `UHIS_LINE_SE0);
    assign was_se0 = (prev_reg == `UHIS_LINE_SE0);
    assign is_idle = (line == `UHIS_LINE_IDLE_FS) ||
        (line == `UHIS_LINE_IDLE_LS);
    assign was_idle = (prev_reg == `UHIS_LINE_IDLE_FS) ||
        (prev_reg == `UHIS_LINE_IDLE_LS);
    // pulse on se0 to idle or idle to se0
    assign change_o = ce_i && seen_reg &&
        ((was_se0 && is_idle) || (was_idle && is_se0));
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prev_reg <= `UHIS_LINE_SE0;
            seen_reg <= 1'b0;
        end else if (ce_i) begin
            prev_reg <= line;
            seen_reg <= 1'b1;
        end
    end
endmodule // uhis_line_watch
`default_nettype wire

/* File: uhis_top.v */
// interrupt status register, revision read and interrupt request pin
`timescale 1ns/1ps
`default_nettype none
`include "uhis_defs.vh"
module uhis_top #(
    parameter [3:0] REVISION = 4'h5 // arbitrary value
) (
    // clock and reset
    input wire mclk_i,
    input wire arst_n_i,
    input wire ce_i,
    // register port, address already latched by the port logic
    input wire [7:0] reg_addr_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [7:0] reg_wdata_i,
    output reg [7:0] reg_rdata_o,
    // configuration from other registers
    input wire resume_mode_i,
    input wire [7:0] int_enable_i,
    // events
    input wire dplus_i,
    input wire dminus_i,
    input wire device_present_i,
    input wire resume_event_i,
    input wire sof_tick_i,
    input wire done_a_event_i,
    input wire done_b_event_i,
    input wire [7:0] pkt_status_a_i,
    input wire [7:0] pkt_status_b_i,
    // outputs
    output reg [7:0] pkt_status_a_o,
    output reg [7:0] pkt_status_b_o,
    output reg [7:0] sof_low_o,
    output reg sof_low_load_o,
    output wire interrupt_request_pin_o
);
    // reset release chain and its synchronous copy
    reg [1:0] rst_sync_reg;
    wire rst_n;
    // sticky flag storage
    reg [7:0] flags_reg;
    reg [7:0] flags_next;
    reg [7:0] set_vec;
    reg [7:0] clr_vec;
    // register port decode
    wire line_change;
    wire wr_status;
    wire wr_rev;
    wire rd_status;
    wire rd_rev;
    wire rd_any;
    // read view and next values of the registered outputs
    reg [7:0] status_view;
    reg [7:0] rdata_next;
    reg [7:0] sof_low_next;
    reg sof_low_load_next;
    reg [7:0] pkt_status_a_next;
    reg [7:0] pkt_status_b_next;
    wire [7:0] rev_word;

    // true when a strobe addresses the given register
    function addr_hit;
        input strobe;
        input [7:0] addr;
        input [7:0] target;
        begin
            addr_hit = strobe && (addr == target);
        end
    endfunction

    // keep the old byte unless the load condition holds
    function [7:0] hold_or_load;
        input [7:0] old_value;
        input load;
        input [7:0] new_value;
        begin
            if (load) begin
                hold_or_load = new_value;
            end else begin
                hold_or_load = old_value;
            end
        end
    endfunction

    always @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    uhis_line_watch uhis_line_watch_i (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n),
        .ce_i(ce_i),
        .dplus_i(dplus_i),
        .dminus_i(dminus_i),
        .change_o(line_change)
    );

    // strobes only count in enabled cycles
    assign wr_status = ce_i &&
        addr_hit(reg_wr_i, reg_addr_i, `UHIS_ADDR_STATUS);
    assign wr_rev = ce_i &&
        addr_hit(reg_wr_i, reg_addr_i, `UHIS_ADDR_REV);
    assign rd_status = ce_i &&
        addr_hit(reg_rd_i, reg_addr_i, `UHIS_ADDR_STATUS);
    assign rd_rev = ce_i &&
        addr_hit(reg_rd_i, reg_addr_i, `UHIS_ADDR_REV);
    assign rd_any = ce_i && reg_rd_i;

    // events that raise flags this cycle
    always @* begin
        set_vec = `UHIS_ZERO8;
        if (resume_mode_i) begin
            set_vec[`UHIS_BIT_DETECT] = resume_event_i;
        end
        set_vec[`UHIS_BIT_INSRM] = line_change;
        set_vec[`UHIS_BIT_SOF] = sof_tick_i;
        set_vec[`UHIS_BIT_DONE_B] = done_b_event_i;
        set_vec[`UHIS_BIT_DONE_A] = done_a_event_i;
    end

    // write one to clear; zeros in the write data leave flags alone
    always @* begin
        clr_vec = `UHIS_ZERO8;
        if (wr_status) begin
            clr_vec = reg_wdata_i;
        end
    end

    // set wins over a clear in the same cycle
    always @* begin
        flags_next = flags_reg & ~clr_vec;
        flags_next = (flags_next | set_vec) & `UHIS_STICKY_MASK;
    end

    always @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            flags_reg <= `UHIS_ZERO8;
        end else if (ce_i) begin
            flags_reg <= flags_next;
        end
    end

    // bit 7 live D+, bit 6 detect level or latched resume
    always @* begin
        status_view = flags_reg & `UHIS_STICKY_MASK;
        status_view[`UHIS_BIT_DPLUS] = dplus_i;
        if (resume_mode_i) begin
            status_view[`UHIS_BIT_DETECT] =
                flags_reg[`UHIS_BIT_DETECT];
        end else begin
            status_view[`UHIS_BIT_DETECT] = ~device_present_i;
        end
    end

    // level request while any enabled flag pends; enables only gate it
    assign interrupt_request_pin_o =
        |(status_view & int_enable_i & `UHIS_PIN_MASK);

    assign rev_word = {REVISION, `UHIS_REV_RSVD};

    // read data holds until the next read strobe
    always @* begin
        rdata_next = reg_rdata_o;
        if (rd_status) begin
            rdata_next = status_view;
        end else if (rd_rev) begin
            rdata_next = rev_word;
        end else if (rd_any) begin
            rdata_next = `UHIS_ZERO8;
        end
    end

    // counter low byte on writes to the revision address, packet status on done events
    always @* begin
        sof_low_load_next = wr_rev;
        sof_low_next = hold_or_load(sof_low_o, wr_rev,
            reg_wdata_i);
        pkt_status_a_next = hold_or_load(pkt_status_a_o, done_a_event_i,
            pkt_status_a_i);
        pkt_status_b_next = hold_or_load(pkt_status_b_o, done_b_event_i,
            pkt_status_b_i);
    end

    always @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_o <= `UHIS_ZERO8;
        end else if (ce_i) begin
            reg_rdata_o <= rdata_next;
        end
    end

    always @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            sof_low_o <= `UHIS_ZERO8;
            sof_low_load_o <= 1'b0;
        end else if (ce_i) begin
            sof_low_o <= sof_low_next;
            sof_low_load_o <= sof_low_load_next;
        end
    end

    always @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            pkt_status_a_o <= `UHIS_ZERO8;
            pkt_status_b_o <= `UHIS_ZERO8;
        end else if (ce_i) begin
            pkt_status_a_o <= pkt_status_a_next;
            pkt_status_b_o <= pkt_status_b_next;
        end
    end
endmodule // uhis_top
`default_nettype wire

/* File: uhis_top_monitor.sv */
// assertions on the ports of the interrupt status block
`timescale 1ns/1ps
`default_nettype none
module uhis_top_monitor #(
    parameter [3:0] REVISION = 4'h5 // arbitrary value
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic ce_i,
    // register port
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    // configuration and events
    input wire logic resume_mode_i,
    input wire logic [7:0] int_enable_i,
    input wire logic dplus_i,
    input wire logic device_present_i,
    input wire logic sof_tick_i,
    input wire logic done_a_event_i,
    input wire logic [7:0] pkt_status_a_i,
    // outputs
    input wire logic [7:0] pkt_status_a_o,
    input wire logic [7:0] sof_low_o,
    input wire logic sof_low_load_o,
    input wire logic interrupt_request_pin_o
);
    // follows the design's two-flop reset release
    logic [1:0] rst_q;
    always @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_q <= 2'b00;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_q[1]);
    wire rd = ce_i && reg_rd_i;
    wire wr = ce_i && reg_wr_i;
    wire pin = interrupt_request_pin_o;
    rev_read_a: assert property (rd && reg_addr_i == 8'h0E |=>
        reg_rdata_o == {REVISION, 4'h0}) else $error("bad revision");
    sof_load_a: assert property (wr && reg_addr_i == 8'h0E |=>
        sof_low_load_o && sof_low_o == $past(reg_wdata_i))
        else $error("sof low not loaded");
    dplus_read_a: assert property (rd && reg_addr_i == 8'h0D |=>
        reg_rdata_o[7] == $past(dplus_i)) else $error("bad line bit");
    pin_gate_a: assert property (int_enable_i[6:0] == 7'h00 |->
        !pin) else $error("request while all masked");
    detect_pin_a: assert property (!resume_mode_i &&
        int_enable_i == 8'h40 |-> pin == !device_present_i)
        else $error("bad detect level");
    sof_set_a: assert property (ce_i && sof_tick_i &&
        int_enable_i == 8'h10 |=> pin) else $error("tick not flagged");
    clear_one_a: assert property (wr && reg_addr_i == 8'h0D &&
        reg_wdata_i[4] && !sof_tick_i && int_enable_i == 8'h10 |=> !pin)
        else $error("flag not cleared");
    pkt_capture_a: assert property (ce_i && done_a_event_i |=>
        pkt_status_a_o == $past(pkt_status_a_i)) else $error("no capture");
endmodule // uhis_top_monitor
bind uhis_top uhis_top_monitor #(.REVISION(REVISION)) uhis_top_monitor_i (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o),
    .resume_mode_i(resume_mode_i),
    .int_enable_i(int_enable_i),
    .dplus_i(dplus_i),
    .device_present_i(device_present_i),
    .sof_tick_i(sof_tick_i),
    .done_a_event_i(done_a_event_i),
    .pkt_status_a_i(pkt_status_a_i),
    .pkt_status_a_o(pkt_status_a_o),
    .sof_low_o(sof_low_o),
    .sof_low_load_o(sof_low_load_o),
    .interrupt_request_pin_o(interrupt_request_pin_o)
);
`default_nettype wire

/* File: uhis_usb_dev.sv */
// far-side model: a full-speed device on the bus lines
`timescale 1ns/1ps
`default_nettype none
module uhis_usb_dev (
    input wire logic attach_i,
    output logic dplus_o,
    output logic dminus_o,
    output logic present_o
);
    // detached lines sit at se0, attached at full-speed idle
    assign dplus_o = attach_i;
    assign dminus_o = 1'b0;
    assign present_o = attach_i;
endmodule // uhis_usb_dev
`default_nettype wire

/* File: uhis_top_tb.sv */
// testbench for the interrupt status block
`timescale 1ns/1ps
`default_nettype none
module uhis_top_tb;
    reg mclk_i = 0, arst_n_i = 0, ce_i = 1, reg_wr_i = 0, reg_rd_i = 0;
    reg resume_mode_i = 0, attach = 0;
    reg [3:0] ev = 0;
    reg [7:0] reg_addr_i = 0, reg_wdata_i = 0, int_enable_i = 0;
    reg [7:0] pkt_status_a_i = 8'h3C, pkt_status_b_i = 8'hC3;
    wire [7:0] reg_rdata_o, pkt_status_a_o, pkt_status_b_o, sof_low_o;
    wire dplus_i, dminus_i, device_present_i, sof_low_load_o;
    wire interrupt_request_pin_o;
    wire resume_event_i = ev[3], sof_tick_i = ev[2];
    wire done_a_event_i = ev[1], done_b_event_i = ev[0];
    integer err_total = 0, num_checks = 0;
    always #12.5 mclk_i = ~mclk_i;
    uhis_top uhis_top_i (
        .mclk_i(mclk_i),
        .arst_n_i(arst_n_i),
        .ce_i(ce_i),
        .reg_addr_i(reg_addr_i),
        .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i),
        .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o),
        .resume_mode_i(resume_mode_i),
        .int_enable_i(int_enable_i),
        .dplus_i(dplus_i),
        .dminus_i(dminus_i),
        .device_present_i(device_present_i),
        .resume_event_i(resume_event_i),
        .sof_tick_i(sof_tick_i),
        .done_a_event_i(done_a_event_i),
        .done_b_event_i(done_b_event_i),
        .pkt_status_a_i(pkt_status_a_i),
        .pkt_status_b_i(pkt_status_b_i),
        .pkt_status_a_o(pkt_status_a_o),
        .pkt_status_b_o(pkt_status_b_o),
        .sof_low_o(sof_low_o),
        .sof_low_load_o(sof_low_load_o),
        .interrupt_request_pin_o(interrupt_request_pin_o)
    );
    uhis_usb_dev uhis_usb_dev_i (.attach_i(attach), .dplus_o(dplus_i),
        .dminus_o(dminus_i), .present_o(device_present_i));
    task chk(input [7:0] seen, input [7:0] exp);
        begin
            num_checks = num_checks + 1;
            if (seen !== exp) begin
                err_total = err_total + 1;
                $display("mismatch %0t: got %h want %h", $time, seen, exp);
            end
        end
    endtask
    task acc(input w, input [7:0] a, input [7:0] d);
        begin
            @(posedge mclk_i) #1 reg_addr_i = a;
            reg_wdata_i = d;
            reg_wr_i = w;
            reg_rd_i = !w;
            @(posedge mclk_i) #1 reg_wr_i = 0;
            reg_rd_i = 0;
            if (!w) chk(reg_rdata_o, d);
        end
    endtask
    task pulse(input [3:0] m);
        begin
            @(posedge mclk_i) #1 ev = m;
            @(posedge mclk_i) #1 ev = 0;
        end
    endtask
    task en(input [7:0] v, input e);
        begin
            @(posedge mclk_i) #1 int_enable_i = v;
            #2 chk({7'h00, interrupt_request_pin_o}, {7'h00, e});
        end
    endtask
    task results;
        begin
            $display("checks %0d mismatches %0d", num_checks, err_total);
            if (err_total == 0 && num_checks > 0) $display("== PASSED ==");
            else $display("== FAILED ==");
            $finish;
        end
    endtask
    initial begin
        #100000 err_total = err_total + 1;
        results;
    end
    initial begin
        repeat (8) @(posedge mclk_i);
        #1 arst_n_i = 1;
        repeat (3) @(posedge mclk_i);
        acc(0, 8'h0D, 8'h40);
        @(posedge mclk_i) #1 attach = 1;
        repeat (4) @(posedge mclk_i);
        acc(0, 8'h0D, 8'hA0);
        acc(1, 8'h0D, 8'h20);
        acc(0, 8'h0D, 8'h80);
        en(8'h10, 0);
        pulse(4'h4);
        pulse(4'h3);
        chk(pkt_status_a_o, 8'h3C);
        chk(pkt_status_b_o, 8'hC3);
        acc(0, 8'h0D, 8'h93);
        acc(1, 8'h0D, 8'h10);
        en(8'h03, 1);
        acc(1, 8'h0D, 8'h03);
        en(8'h03, 0);
        @(posedge mclk_i) #1 resume_mode_i = 1;
        pulse(4'h8);
        acc(0, 8'h0D, 8'hC0);
        acc(1, 8'h0D, 8'h40);
        resume_mode_i = 0;
        attach = 0;
        repeat (4) @(posedge mclk_i);
        acc(0, 8'h0D, 8'h60);
        en(8'h40, 1);
        acc(0, 8'h0E, 8'h50);
        acc(1, 8'h0E, 8'hE0);
        chk(sof_low_o, 8'hE0);
        chk({7'h00, sof_low_load_o}, 8'h01);
        acc(0, 8'h07, 8'h00);
        chk({7'h00, sof_low_load_o}, 8'h00);
        @(posedge mclk_i) #1 ce_i = 0;
        pulse(4'h4);
        ce_i = 1;
        acc(0, 8'h0D, 8'h60);
        results;
    end
endmodule // uhis_top_tb
`default_nettype wire
